/* serial_events.sv */
// serial character engine with parity, status flags, clear sequences and shared event line
// assumes apb master on pclk; rxd, halt_mode, cpu_irq_mask and lin_header_evt synchronous to pclk
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module serial_events
   import serial_pkg::*;
#(
   parameter logic [15:0] BAUD_DIV_DEFAULT = BAUD_RST
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd,
   output logic txd,
   input wire logic halt_mode,
   input wire logic cpu_irq_mask,
   input wire logic lin_header_evt,
   output logic irq,
   output logic wake_req
);

   state_t s;
   state_t n;
   state_t frz;

   always_comb begin
      logic tick;
      logic access;
      logic [7:0] clr;
      logic clr_lin;
      logic [8:0] payload;
      logic [10:0] frame;
      logic maj;
      logic [8:0] d9;
      logic par_bad;
      logic msb;
      logic muted;
      logic events;
      tick = 1'b0;
      access = 1'b0;
      clr = 8'h00;
      clr_lin = 1'b0;
      payload = 9'h000;
      frame = 11'h000;
      maj = 1'b0;
      d9 = 9'h000;
      par_bad = 1'b0;
      msb = 1'b0;
      muted = 1'b0;
      events = 1'b0;
      n = s;

      // apb: answer one cycle after setup, zero wait states
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (psel && !penable) begin
         n.pready = 1'b1;
         n.prdata = 32'h0000_0000;
         if (paddr == OFS_STATUS) begin
            n.prdata[7:0] = s.status;
         end else if (paddr == OFS_DATA) begin
            n.prdata[7:0] = s.rx_hold[7:0];
         end else if (paddr == OFS_CTRL_ONE) begin
            n.prdata[7:0] = s.ctrl_one;
         end else if (paddr == OFS_CTRL_TWO) begin
            n.prdata[7:0] = s.ctrl_two;
         end else if (paddr == OFS_BAUD) begin
            n.prdata[15:0] = s.baud_div;
         end else if (paddr == OFS_AUX) begin
            n.prdata[AUX_LIN_IRQ] = s.lin_irq_en;
            n.prdata[AUX_LIN_FLAG] = s.lin_flag;
         end else begin
            n.pslverr = 1'b1;
         end
      end
      access = psel && penable && s.pready && !s.pslverr;

      if (access) begin
         if (paddr == OFS_STATUS) begin
            n.armed = {s.lin_flag, s.status};
         end else if (paddr == OFS_DATA) begin
            if (pwrite) begin
               n.tx_hold = pwdata[7:0];
               n.tx_pending = 1'b1;
               clr[ST_TX_EMPTY] = s.armed[ST_TX_EMPTY];
               clr[ST_TX_DONE] = s.armed[ST_TX_DONE];
            end else begin
               clr[5:1] = s.armed[5:1];
               clr_lin = s.armed[8];
            end
            clr[ST_PARITY] = s.armed[ST_PARITY];
            n.armed = 9'h000;
         end else if (pwrite && paddr == OFS_CTRL_ONE) begin
            n.ctrl_one[6:0] = pwdata[6:0];
         end else if (pwrite && paddr == OFS_CTRL_TWO) begin
            n.ctrl_two = pwdata[7:0];
            if (s.ctrl_one[C1_WAKE_ADDR] && s.status[ST_RX_FULL]) begin
               n.ctrl_two[C2_RWU] = s.ctrl_two[C2_RWU];
            end
         end else if (pwrite && paddr == OFS_BAUD) begin
            n.baud_div = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
         end else if (pwrite && paddr == OFS_AUX) begin
            n.lin_irq_en = pwdata[AUX_LIN_IRQ];
         end
      end
      // clears first; hardware sets below win in the same cycle
      n.status = s.status & ~clr;
      if (clr_lin) begin
         n.lin_flag = 1'b0;
      end
      if (lin_header_evt) begin
         n.lin_flag = 1'b1;
      end

      // oversampling tick
      tick = (s.baud_cnt == 16'h0000);
      n.baud_cnt = tick ? s.baud_div - 16'h0001 : s.baud_cnt - 16'h0001;

      // transmitter
      if (tick) begin
         case (s.tx_st)
            TX_IDLE: begin
               n.txd = 1'b1;
               if (s.ctrl_two[C2_TE] && s.ctrl_two[C2_SBK]) begin
                  n.tx_st = TX_SHIFT;
                  n.tx_word9 = s.ctrl_one[C1_WORD9];
                  n.tx_sh = 10'h000;
                  n.tx_data_frame = 1'b0;
                  n.txd = 1'b0;
                  n.tx_bits = 4'h0;
                  n.tx_ticks = 4'h0;
               end else if (s.ctrl_two[C2_TE] && s.tx_pending) begin
                  payload = {s.ctrl_one[C1_T8], s.tx_hold};
                  if (s.ctrl_one[C1_PAR_EN]) begin
                     if (s.ctrl_one[C1_WORD9]) begin
                        payload[8] = ^s.tx_hold ^ s.ctrl_one[C1_PAR_ODD];
                     end else begin
                        payload[7] = ^s.tx_hold[6:0] ^ s.ctrl_one[C1_PAR_ODD];
                     end
                  end
                  frame = s.ctrl_one[C1_WORD9] ? {1'b1, payload, 1'b0}
                                               : {2'b11, payload[7:0], 1'b0};
                  n.tx_sh = frame[10:1];
                  n.tx_word9 = s.ctrl_one[C1_WORD9];
                  n.tx_pending = 1'b0;
                  n.status[ST_TX_EMPTY] = 1'b1;
                  n.tx_data_frame = 1'b1;
                  n.tx_st = TX_SHIFT;
                  n.txd = 1'b0;
                  n.tx_bits = 4'h0;
                  n.tx_ticks = 4'h0;
               end
            end
            TX_SHIFT: begin
               n.tx_ticks = s.tx_ticks + 4'h1;
               if (s.tx_ticks == TICK_LAST) begin
                  if (s.tx_bits == (s.tx_word9 ? 4'(FRAME_9 - 1) : 4'(FRAME_8 - 1))) begin
                     n.tx_st = TX_IDLE;
                     n.txd = 1'b1;
                     if (s.tx_data_frame) begin
                        n.status[ST_TX_DONE] = 1'b1;
                     end
                  end else begin
                     n.txd = s.tx_sh[0];
                     n.tx_sh = {1'b0, s.tx_sh[9:1]};
                     n.tx_bits = s.tx_bits + 4'h1;
                  end
               end
            end
            default: n.tx_st = TX_IDLE;
         endcase
      end

      // receiver: majority of three mid-bit samples, noise on any disagreement in the start or data bits
      muted = s.ctrl_two[C2_RWU];
      if (tick) begin
         case (s.rx_st)
            RX_IDLE: begin
               if (s.ctrl_two[C2_RE] && !rxd) begin
                  n.rx_st = RX_BUSY;
                  n.rx_ticks = 4'h0;
                  n.rx_bits = 4'h0;
                  n.rx_noise = 1'b0;
                  n.rx_word9 = s.ctrl_one[C1_WORD9];
                  n.rx_par_en = s.ctrl_one[C1_PAR_EN];
                  n.rx_odd = s.ctrl_one[C1_PAR_ODD];
                  n.idle_cnt = 8'h00;
               end else if (rxd && s.ctrl_two[C2_RE]) begin
                  if (s.idle_cnt != (s.ctrl_one[C1_WORD9] ? IDLE_LIM_9 : IDLE_LIM_8)) begin
                     n.idle_cnt = s.idle_cnt + 8'h01;
                  end else if (muted && !s.ctrl_one[C1_WAKE_ADDR]) begin
                     n.ctrl_two[C2_RWU] = 1'b0;
                  end else if (s.idle_armed && !muted) begin
                     n.status[ST_QUIET] = 1'b1;
                     n.idle_armed = 1'b0;
                  end
               end else begin
                  n.idle_cnt = 8'h00;
               end
            end
            RX_BUSY: begin
               n.rx_ticks = s.rx_ticks + 4'h1;
               if (s.rx_ticks == SMP_A) begin
                  n.rx_smp[0] = rxd;
               end
               if (s.rx_ticks == SMP_B) begin
                  n.rx_smp[1] = rxd;
               end
               if (s.rx_ticks == SMP_C) begin
                  maj = (s.rx_smp[0] & s.rx_smp[1]) | (s.rx_smp[0] & rxd) | (s.rx_smp[1] & rxd);
                  n.rx_noise = s.rx_noise | ~((s.rx_smp == 2'b11 && rxd) ||
                                              (s.rx_smp == 2'b00 && !rxd));
                  if (s.rx_bits == 4'h0) begin
                     if (maj) begin
                        n.rx_st = RX_IDLE;
                     end
                  end else if (s.rx_bits != (s.rx_word9 ? 4'(FRAME_9 - 1) : 4'(FRAME_8 - 1))) begin
                     n.rx_sh = {maj, s.rx_sh[8:1]};
                  end else begin
                     n.rx_st = RX_IDLE;
                     d9 = s.rx_word9 ? s.rx_sh : {1'b0, s.rx_sh[8:1]};
                     par_bad = s.rx_par_en &&
                               ((s.rx_word9 ? ^d9[8:0] : ^d9[7:0]) != s.rx_odd);
                     if (s.rx_par_en) begin
                        msb = s.rx_word9 ? d9[7] : d9[6];
                     end else begin
                        msb = s.rx_word9 ? d9[8] : d9[7];
                     end
                     if (!muted || (s.ctrl_one[C1_WAKE_ADDR] && msb)) begin
                        n.ctrl_two[C2_RWU] = 1'b0;
                        if (s.status[ST_RX_FULL]) begin
                           n.status[ST_OVERRUN] = 1'b1;
                        end else begin
                           n.rx_hold = d9;
                           n.ctrl_one[C1_R8] = d9[8];
                           n.status[ST_RX_FULL] = 1'b1;
                           n.idle_armed = 1'b1;
                           n.status[ST_NOISE] = n.status[ST_NOISE] | s.rx_noise | ~maj;
                           n.status[ST_FRAMING] = n.status[ST_FRAMING] | ~maj;
                           n.status[ST_PARITY] = n.status[ST_PARITY] | par_bad;
                        end
                     end
                  end
               end
               if (s.rx_ticks == TICK_LAST) begin
                  n.rx_bits = s.rx_bits + 4'h1;
               end
            end
            default: n.rx_st = RX_IDLE;
         endcase
      end

      // shared event line
      events = (s.status[ST_TX_EMPTY] & s.ctrl_two[C2_TIE]) |
               (s.status[ST_TX_DONE] & s.ctrl_two[C2_TX_DONE_IRQ_EN]) |
               ((s.status[ST_RX_FULL] | s.status[ST_OVERRUN]) & s.ctrl_two[C2_RIE]) |
               (s.status[ST_QUIET] & s.ctrl_two[C2_QUIET_LINE_IRQ_EN]) |
               (s.status[ST_PARITY] & s.ctrl_one[C1_PAR_IRQ]) |
               (s.lin_flag & s.lin_irq_en);
      n.irq = events & ~cpu_irq_mask;
      n.wake_req = events & ~halt_mode;

      // halt: everything holds except the bus answer and wake_req, which is forced low
      frz = s;
      frz.prdata = n.prdata;
      frz.pready = n.pready;
      frz.pslverr = n.pslverr;
      frz.wake_req = 1'b0;
      if (halt_mode) begin
         n = frz;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.txd <= 1'b1;
         s.status <= STATUS_RST;
         s.ctrl_one <= CTRL_ONE_RST;
         s.ctrl_two <= CTRL_TWO_RST;
         s.baud_div <= BAUD_DIV_DEFAULT;
         s.tx_st <= TX_IDLE;
         s.rx_st <= RX_IDLE;
      end else begin
         s <= n;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign txd = s.txd;
   assign irq = s.irq;
   assign wake_req = s.wake_req;

endmodule
`default_nettype wire

/* serial_pkg.sv */
// package for the serial parity, status and event block
// assumes a single apb clock domain; offsets are byte addresses of 32-bit words
package serial_pkg;
   // register offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_CTRL_ONE = 8'h08;
   localparam logic [7:0] OFS_CTRL_TWO = 8'h0c;
   localparam logic [7:0] OFS_BAUD = 8'h10;
   localparam logic [7:0] OFS_AUX = 8'h14;
   // serial_status fields
   localparam int ST_TX_EMPTY = 7;
   localparam int ST_TX_DONE = 6;
   localparam int ST_RX_FULL = 5;
   localparam int ST_QUIET = 4;
   localparam int ST_OVERRUN = 3;
   localparam int ST_NOISE = 2;
   localparam int ST_FRAMING = 1;
   localparam int ST_PARITY = 0;
   // serial_ctrl_one fields
   localparam int C1_R8 = 7;
   localparam int C1_T8 = 6;
   localparam int C1_WORD9 = 4;
   localparam int C1_WAKE_ADDR = 3;
   localparam int C1_PAR_EN = 2;
   localparam int C1_PAR_ODD = 1;
   localparam int C1_PAR_IRQ = 0;
   // serial_ctrl_two fields
   localparam int C2_TIE = 7;
   localparam int C2_TX_DONE_IRQ_EN = 6;
   localparam int C2_RIE = 5;
   localparam int C2_QUIET_LINE_IRQ_EN = 4;
   localparam int C2_TE = 3;
   localparam int C2_RE = 2;
   localparam int C2_RWU = 1;
   localparam int C2_SBK = 0;
   // aux fields
   localparam int AUX_LIN_IRQ = 0;
   localparam int AUX_LIN_FLAG = 1;
   // reset values
   localparam logic [7:0] STATUS_RST = 8'hc0;
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] CTRL_TWO_RST = 8'h00;
   localparam logic [15:0] BAUD_RST = 16'h0001;
   // timing: ticks per bit, sample points, frame lengths
   localparam int OVS = 16;
   localparam logic [3:0] SMP_A = 4'h7;
   localparam logic [3:0] SMP_B = 4'h8;
   localparam logic [3:0] SMP_C = 4'h9;
   localparam logic [3:0] TICK_LAST = 4'(OVS - 1);
   localparam int FRAME_8 = 10;
   localparam int FRAME_9 = 11;
   localparam logic [7:0] IDLE_LIM_8 = 8'(FRAME_8 * OVS - 1);
   localparam logic [7:0] IDLE_LIM_9 = 8'(FRAME_9 * OVS - 1);

   typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
   typedef enum logic {RX_IDLE, RX_BUSY} rx_state_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic txd;
      logic irq;
      logic wake_req;
      logic [7:0] status;
      logic lin_flag;
      logic [8:0] armed;
      logic [7:0] ctrl_one;
      logic [7:0] ctrl_two;
      logic lin_irq_en;
      logic [15:0] baud_div;
      logic [15:0] baud_cnt;
      logic [7:0] tx_hold;
      logic tx_pending;
      tx_state_t tx_st;
      logic [9:0] tx_sh;
      logic [3:0] tx_bits;
      logic [3:0] tx_ticks;
      logic tx_data_frame;
      logic tx_word9;
      rx_state_t rx_st;
      logic [3:0] rx_ticks;
      logic [3:0] rx_bits;
      logic [8:0] rx_sh;
      logic [1:0] rx_smp;
      logic rx_noise;
      logic rx_odd;
      logic rx_word9;
      logic rx_par_en;
      logic [8:0] rx_hold;
      logic idle_armed;
      logic [7:0] idle_cnt;
   } state_t;
endpackage

/* serial_events_properties.sv */
// checker for the serial event block: bus answer, halt freezing, event line, start bit
// assumes it is bound onto serial_events with a baud divider of 1
`timescale 1ns/1ps
`default_nettype none
module serial_events_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic txd,
   input wire logic halt_mode,
   input wire logic cpu_irq_mask,
   input wire logic irq,
   input wire logic wake_req
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("answer held too long");
   a_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error answer without zero data");
   a_irq_mask_gate: assert property (cpu_irq_mask && $past(cpu_irq_mask) && !halt_mode && !$past(halt_mode) |-> !irq)
      else $error("event line high while masked");
   a_wake_follows_irq: assert property (irq && !halt_mode && !$past(halt_mode) |-> wake_req)
      else $error("event line without wake request");
   a_wake_off_halt: assert property (halt_mode && $past(halt_mode) |-> !wake_req)
      else $error("wake request during halt");
   a_txd_halt_frozen: assert property (halt_mode && $past(halt_mode) |-> $stable(txd))
      else $error("transmit line moved during halt");
   a_irq_halt_frozen: assert property (halt_mode && $past(halt_mode) |-> $stable(irq))
      else $error("event line moved during halt");
   a_start_bit_len: assert property ($fell(txd) |=> !txd [*8])
      else $error("start bit too short");
endmodule
bind serial_events serial_events_properties i_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .txd(txd), .halt_mode(halt_mode), .cpu_irq_mask(cpu_irq_mask), .irq(irq),
   .wake_req(wake_req));
`default_nettype wire

/* remote_node.sv */
// remote serial node: drives the receive line and captures frames from the transmit line
// assumes one bit lasts 16 pclk cycles (baud divider 1); the line idles high
`timescale 1ns/1ps
`default_nettype none
module remote_node (
   input wire logic pclk,
   input wire logic txd,
   output logic rxd
);
   localparam int BIT_CYC = 16;
   initial rxd = 1'b1;
   // start bit, data lsb first, stop bit, then idle high
   task automatic send(input logic [9:0] fr);
      for (int i = 0; i < 10; i++) begin
         rxd <= fr[i];
         repeat (BIT_CYC) @(posedge pclk);
      end
      rxd <= 1'b1;
   endtask
   // waits for a start bit, then samples n data bits and the stop bit mid-bit
   task automatic recv(input int n, output logic [10:0] b);
      int t;
      b = 11'h000;
      t = 0;
      while (txd !== 1'b0 && t < 400) begin
         @(posedge pclk);
         t++;
      end
      repeat (BIT_CYC / 2) @(posedge pclk);
      for (int i = 0; i <= n; i++) begin
         repeat (BIT_CYC) @(posedge pclk);
         b[i] = txd;
      end
   endtask
endmodule
`default_nettype wire

/* serial_events_test.sv */
// self-checking bench: apb register tasks and serial frames through the remote node
// assumes serial_events with its default baud divider and a 250 mhz pclk
`timescale 1ns/1ps
`default_nettype none
module serial_events_test
   import serial_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, txd, rxd, irq, wake_req, err;
   logic halt_mode = 1'b0, cpu_irq_mask = 1'b0, lin_header_evt = 1'b0;
   logic [10:0] fr, e;
   int error_cnt = 0, compares = 0;
   always #2 pclk = ~pclk;
   serial_events i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rxd(rxd), .txd(txd), .halt_mode(halt_mode),
      .cpu_irq_mask(cpu_irq_mask), .lin_header_evt(lin_header_evt), .irq(irq),
      .wake_req(wake_req));
   remote_node i_node (.pclk(pclk), .txd(txd), .rxd(rxd));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 50);
      if (t == 50) error_cnt++;
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q & m, x);
   endtask
   task automatic finish_test;
      $display("counts: %0d compares, %0d mismatches", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge pclk);
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_STATUS, 32'hffffffff, 32'hc0);
      rd(OFS_CTRL_ONE, 32'hffffffff, 32'h00);
      rd(8'h18, 32'hffffffff, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test reset done");
      apb(1'b1, OFS_CTRL_TWO, 32'h08);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, OFS_CTRL_ONE, {25'h0, 1'b1, 1'b0, i[0], 1'b0, i[1], i[2], 1'b0});
         e = i[0] ? 11'h335 : 11'h135;
         if (i[1] && !i[0]) e[7] = ^e[6:0] ^ i[2];
         if (i[1] && i[0]) e[8] = ^e[7:0] ^ i[2];
         apb(1'b0, OFS_STATUS, 32'h0);
         fork
            i_node.recv(i[0] ? 9 : 8, fr);
            begin
               apb(1'b1, OFS_DATA, 32'h35);
               rd(OFS_STATUS, 32'hc0, 32'h80);
            end
         join
         repeat (12) @(posedge pclk);
         chk({21'h0, fr}, {21'h0, e});
         rd(OFS_STATUS, 32'hc0, 32'hc0);
      end
      $display("test transmit formats done");
      apb(1'b1, OFS_CTRL_ONE, 32'h07);
      apb(1'b1, OFS_CTRL_TWO, 32'h2c);
      i_node.send({1'b1, 8'hb5, 1'b0});
      rd(OFS_STATUS, 32'h2f, 32'h20);
      chk({31'h0, irq}, 32'h1);
      cpu_irq_mask <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({30'h0, irq, wake_req}, 32'h1);
      cpu_irq_mask <= 1'b0;
      i_node.send({1'b1, 8'hca, 1'b0});
      rd(OFS_STATUS, 32'h2f, 32'h28);
      rd(OFS_DATA, 32'h7f, 32'h35);
      rd(OFS_STATUS, 32'h2f, 32'h00);
      $display("test receive and overrun done");
      i_node.send({1'b1, 8'hca, 1'b0});
      rd(OFS_STATUS, 32'h2f, 32'h21);
      apb(1'b0, OFS_DATA, 32'h0);
      rd(OFS_STATUS, 32'h2f, 32'h00);
      i_node.send({1'b0, 8'hb5, 1'b0});
      rd(OFS_STATUS, 32'h2b, 32'h22);
      apb(1'b0, OFS_DATA, 32'h0);
      repeat (200) @(posedge pclk);
      rd(OFS_STATUS, 32'h10, 32'h10);
      apb(1'b0, OFS_DATA, 32'h0);
      repeat (200) @(posedge pclk);
      rd(OFS_STATUS, 32'h10, 32'h00);
      $display("test error flags done");
      halt_mode <= 1'b1;
      apb(1'b1, OFS_CTRL_TWO, 32'h00);
      rd(OFS_CTRL_TWO, 32'hff, 32'h2c);
      chk({31'h0, wake_req}, 32'h0);
      halt_mode <= 1'b0;
      $display("test halt done");
      apb(1'b1, OFS_CTRL_ONE, 32'h0c);
      apb(1'b1, OFS_CTRL_TWO, 32'h2e);
      i_node.send({1'b1, 8'h8b, 1'b0});
      repeat (4) @(posedge pclk);
      rd(OFS_STATUS, 32'h20, 32'h00);
      rd(OFS_CTRL_TWO, 32'hff, 32'h2e);
      i_node.send({1'b1, 8'hc0, 1'b0});
      rd(OFS_STATUS, 32'h21, 32'h20);
      rd(OFS_CTRL_TWO, 32'hff, 32'h2c);
      rd(OFS_DATA, 32'hff, 32'hc0);
      apb(1'b1, OFS_AUX, 32'h1);
      lin_header_evt <= 1'b1;
      @(posedge pclk);
      lin_header_evt <= 1'b0;
      rd(OFS_AUX, 32'h3, 32'h3);
      $display("test address wake done");
      finish_test();
   end
endmodule
`default_nettype wire
